// File: src/inband_loop_code_gen_detect.sv
// In-band loop code generator, two detectors and their register port.
//
// Overview of operation
// - Loop pattern replaces transmit data while the send enable bit is set.
// - Framing bit slot overwrites a pattern bit unless framing insertion off.
// - Transmit pattern is sent most significant bit first.
// - Pattern bits below the selected transmit length are ignored.
// - Separate up and down detectors with their own three-bit length fields.
// - Receive length equals field value plus one.
// - Detection works framed or unframed and tolerates one error per hundred.
// - About 48 ms of a code sets the up or down seen status bit.
// - Up pattern compared top bit first, unused low bits ignored.
// - Down pattern compared the same way.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module inband_loop_code_gen_detect #(
  parameter int WINDOW_BITS = loop_code_pkg::WINDOW_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic txBitStrobe,
  input wire logic txPayloadBit,
  input wire logic txFrameSlot,
  input wire logic txFrameBit,
  input wire logic frameInsertEnable,
  output logic txLineBit,
  input wire logic rxBitStrobe,
  input wire logic rxBit,
  output logic irq
);
  logic [7:0] codeControl_r, codeControl_nxt;
  logic [7:0] txPattern_r, txPattern_nxt;
  logic [7:0] upPattern_r, upPattern_nxt;
  logic [7:0] downPattern_r, downPattern_nxt;
  logic [7:0] commonControl_r, commonControl_nxt;
  logic [7:0] irqEnable_r, irqEnable_nxt;
  logic [7:0] status_r, status_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic [2:0] txIndex_r, txIndex_nxt;
  logic txLineBit_r, txLineBit_nxt;
  logic upSeen, downSeen;
  logic upSeenPrev_r, downSeenPrev_r;
  logic [7:0] events;
  logic [7:0] clearMask;
  logic [2:0] txLast;
  logic sendEnable;

  // Last bit index of the transmit pattern for the selected length.
  function automatic logic [2:0] txLastIndex(input logic [1:0] sel);
    case (sel)
      loop_code_pkg::TX_LEN_FIVE: txLastIndex = 3'h4;
      loop_code_pkg::TX_LEN_SIX: txLastIndex = 3'h5;
      loop_code_pkg::TX_LEN_SEVEN: txLastIndex = 3'h6;
      default: txLastIndex = 3'h7;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign rdData = rdData_r;
  assign txLineBit = txLineBit_r;
  assign irq = |(status_r & irqEnable_r);
  assign sendEnable =
    commonControl_r[loop_code_pkg::SEND_LOOP_CODE_ENABLE_POS];
  assign txLast = txLastIndex({
    codeControl_r[loop_code_pkg::TX_LEN_SEL_HI_POS],
    codeControl_r[loop_code_pkg::TX_LEN_SEL_LO_POS]});

  loop_code_detector #(.WINDOW_BITS(WINDOW_BITS)) upDetector (
    .clk(clk),
    .rst(rst),
    .bitStrobe(rxBitStrobe),
    .rxBit(rxBit),
    .pattern(upPattern_r),
    .lengthSel(codeControl_r[loop_code_pkg::UP_LEN_SEL_MSB:
                             loop_code_pkg::UP_LEN_SEL_LSB]),
    .detected(upSeen)
  );

  loop_code_detector #(.WINDOW_BITS(WINDOW_BITS)) downDetector (
    .clk(clk),
    .rst(rst),
    .bitStrobe(rxBitStrobe),
    .rxBit(rxBit),
    .pattern(downPattern_r),
    .lengthSel(codeControl_r[loop_code_pkg::DOWN_LEN_SEL_MSB:
                             loop_code_pkg::DOWN_LEN_SEL_LSB]),
    .detected(downSeen)
  );

  // Register writes and reads.
  always_comb begin
    codeControl_nxt = codeControl_r;
    txPattern_nxt = txPattern_r;
    upPattern_nxt = upPattern_r;
    downPattern_nxt = downPattern_r;
    commonControl_nxt = commonControl_r;
    irqEnable_nxt = irqEnable_r;
    rdData_nxt = 8'h00;
    if (wrStrobe) begin
      if (hit(addr, loop_code_pkg::CODE_CONTROL_OFFSET)) begin
        codeControl_nxt = wrData;
      end
      if (hit(addr, loop_code_pkg::TX_PATTERN_OFFSET)) begin
        txPattern_nxt = wrData;
      end
      if (hit(addr, loop_code_pkg::UP_PATTERN_OFFSET)) begin
        upPattern_nxt = wrData;
      end
      if (hit(addr, loop_code_pkg::DOWN_PATTERN_OFFSET)) begin
        downPattern_nxt = wrData;
      end
      if (hit(addr, loop_code_pkg::COMMON_CONTROL_THREE_OFFSET)) begin
        commonControl_nxt = wrData;
      end
      if (hit(addr, loop_code_pkg::IRQ_ENABLE_OFFSET)) begin
        irqEnable_nxt = wrData;
      end
    end
    if (rdStrobe) begin
      case (addr)
        loop_code_pkg::CODE_CONTROL_OFFSET: rdData_nxt = codeControl_r;
        loop_code_pkg::TX_PATTERN_OFFSET: rdData_nxt = txPattern_r;
        loop_code_pkg::UP_PATTERN_OFFSET: rdData_nxt = upPattern_r;
        loop_code_pkg::DOWN_PATTERN_OFFSET: rdData_nxt = downPattern_r;
        loop_code_pkg::STATUS_ONE_OFFSET: rdData_nxt = status_r;
        loop_code_pkg::COMMON_CONTROL_THREE_OFFSET: begin
          rdData_nxt = commonControl_r;
        end
        loop_code_pkg::IRQ_ENABLE_OFFSET: rdData_nxt = irqEnable_r;
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  // Sticky status: a detector rising edge sets a bit, and wins over a clear.
  always_comb begin
    events = 8'h00;
    events[loop_code_pkg::LOOP_UP_SEEN_POS] = upSeen & ~upSeenPrev_r;
    events[loop_code_pkg::LOOP_DOWN_SEEN_POS] =
      downSeen & ~downSeenPrev_r;
    clearMask = 8'h00;
    if (wrStrobe && hit(addr, loop_code_pkg::STATUS_CLEAR_OFFSET)) begin
      clearMask = wrData;
    end
    status_nxt = (status_r & ~clearMask) | events;
  end

  // Pattern generator and transmit bit selection.
  always_comb begin
    txIndex_nxt = txIndex_r;
    txLineBit_nxt = txLineBit_r;
    if (!sendEnable) begin
      txIndex_nxt = 3'h0;
    end
    if (txBitStrobe) begin
      if (sendEnable) begin
        // Low bits past txLast are never indexed.
        txLineBit_nxt = txPattern_r[3'h7 - txIndex_r];
        if (txIndex_r >= txLast) begin
          txIndex_nxt = 3'h0;
        end else begin
          txIndex_nxt = txIndex_r + 3'h1;
        end
      end else begin
        txLineBit_nxt = txPayloadBit;
      end
      if (txFrameSlot && frameInsertEnable) begin
        txLineBit_nxt = txFrameBit;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      codeControl_r <= loop_code_pkg::REG_RESET;
      txPattern_r <= loop_code_pkg::REG_RESET;
      upPattern_r <= loop_code_pkg::REG_RESET;
      downPattern_r <= loop_code_pkg::REG_RESET;
      commonControl_r <= loop_code_pkg::REG_RESET;
      irqEnable_r <= loop_code_pkg::REG_RESET;
      status_r <= loop_code_pkg::REG_RESET;
      rdData_r <= 8'h00;
      txIndex_r <= 3'h0;
      txLineBit_r <= 1'b0;
      upSeenPrev_r <= 1'b0;
      downSeenPrev_r <= 1'b0;
    end else begin
      codeControl_r <= codeControl_nxt;
      txPattern_r <= txPattern_nxt;
      upPattern_r <= upPattern_nxt;
      downPattern_r <= downPattern_nxt;
      commonControl_r <= commonControl_nxt;
      irqEnable_r <= irqEnable_nxt;
      status_r <= status_nxt;
      rdData_r <= rdData_nxt;
      txIndex_r <= txIndex_nxt;
      txLineBit_r <= txLineBit_nxt;
      upSeenPrev_r <= upSeen;
      downSeenPrev_r <= downSeen;
    end
  end
endmodule
`default_nettype wire

// File: src/loop_code_pkg.sv
// Package with register map, field layout and timing for the loop code block.
package loop_code_pkg;
  localparam logic [7:0] CODE_CONTROL_OFFSET = 8'h12;
  localparam logic [7:0] TX_PATTERN_OFFSET = 8'h13;
  localparam logic [7:0] UP_PATTERN_OFFSET = 8'h14;
  localparam logic [7:0] DOWN_PATTERN_OFFSET = 8'h15;
  localparam logic [7:0] STATUS_ONE_OFFSET = 8'h16;
  localparam logic [7:0] COMMON_CONTROL_THREE_OFFSET = 8'h17;
  localparam logic [7:0] STATUS_CLEAR_OFFSET = 8'h18;
  localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h19;

  localparam int TX_LEN_SEL_HI_POS = 7;
  localparam int TX_LEN_SEL_LO_POS = 6;
  localparam int UP_LEN_SEL_MSB = 5;
  localparam int UP_LEN_SEL_LSB = 3;
  localparam int DOWN_LEN_SEL_MSB = 2;
  localparam int DOWN_LEN_SEL_LSB = 0;
  localparam int SEND_LOOP_CODE_ENABLE_POS = 1;
  localparam int LOOP_UP_SEEN_POS = 7;
  localparam int LOOP_DOWN_SEEN_POS = 6;

  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [1:0] TX_LEN_FIVE = 2'h0;
  localparam logic [1:0] TX_LEN_SIX = 2'h1;
  localparam logic [1:0] TX_LEN_SEVEN = 2'h2;
  localparam logic [1:0] TX_LEN_EIGHT = 2'h3;

  localparam int INTEGRATION_MS = 48;
  localparam int LINE_RATE_BPS = 1544000;
  localparam int WINDOW_BITS = (INTEGRATION_MS * LINE_RATE_BPS) / 1000;
  localparam int BAD_FRACTION_DIV = 5;
endpackage

// File: src/loop_code_detector.sv
// One receive loop code detector with a fixed bit integration window.
`timescale 1ns/1ps
`default_nettype none
module loop_code_detector #(
  parameter int WINDOW_BITS = loop_code_pkg::WINDOW_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bitStrobe,
  input wire logic rxBit,
  input wire logic [7:0] pattern,
  input wire logic [2:0] lengthSel,
  output logic detected
);
  localparam int BAD_LIMIT = WINDOW_BITS / loop_code_pkg::BAD_FRACTION_DIV;

  // True when the newest len bits form any rotation of the pattern.
  function automatic logic rotationMatch(input logic [7:0] hist,
                                         input logic [7:0] pat,
                                         input int len);
    logic hit;
    logic all;
    int idx;
    hit = 1'b0;
    for (int r = 0; r < 8; r++) begin
      all = (r < len);
      for (int i = 0; i < 8; i++) begin
        idx = r + len - 1 - i;
        if (idx >= len) begin
          idx = idx - len;
        end
        if (i < len && r < len && hist[i] != pat[7 - idx]) begin
          all = 1'b0;
        end
      end
      hit = hit | all;
    end
    return hit;
  endfunction

  logic [7:0] hist_r, hist_nxt;
  logic [16:0] bitCount_r, bitCount_nxt;
  logic [16:0] badCount_r, badCount_nxt;
  logic detected_r, detected_nxt;
  logic [7:0] histNew;
  int len;

  assign detected = detected_r;

  always_comb begin
    len = int'(lengthSel) + 1;
    histNew = {hist_r[6:0], rxBit};
    hist_nxt = hist_r;
    bitCount_nxt = bitCount_r;
    badCount_nxt = badCount_r;
    detected_nxt = detected_r;
    if (bitStrobe) begin
      hist_nxt = histNew;
      // Alignment free, so framing bits only cost a few bad windows.
      if (!rotationMatch(histNew, pattern, len)) begin
        badCount_nxt = badCount_r + 17'h0_0001;
      end
      if (bitCount_r == 17'(WINDOW_BITS - 1)) begin
        // The window is judged on its full count before the counters restart.
        detected_nxt = (badCount_nxt < 17'(BAD_LIMIT));
        bitCount_nxt = 17'h0_0000;
        badCount_nxt = 17'h0_0000;
      end else begin
        bitCount_nxt = bitCount_r + 17'h0_0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_r <= 8'h00;
      bitCount_r <= 17'h0_0000;
      badCount_r <= 17'h0_0000;
      detected_r <= 1'b0;
    end else begin
      hist_r <= hist_nxt;
      bitCount_r <= bitCount_nxt;
      badCount_r <= badCount_nxt;
      detected_r <= detected_nxt;
    end
  end
endmodule
`default_nettype wire

// File: testbench/loop_code_props.sv
// Port assertions for the loop code block.
`timescale 1ns/1ps
`default_nettype none
module loop_code_props #(
  parameter int WINDOW_BITS = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] rdData,
  input wire logic txBitStrobe,
  input wire logic txPayloadBit,
  input wire logic txFrameSlot,
  input wire logic txFrameBit,
  input wire logic frameInsertEnable,
  input wire logic txLineBit,
  input wire logic rxBitStrobe,
  input wire logic rxBit,
  input wire logic irq
);
  logic en_r, en_nxt, want;
  logic [7:0] ctl_r, ctl_nxt, pat_r, pat_nxt, ie_r, ie_nxt;
  logic [2:0] idx_r, idx_nxt;
  assign want = pat_r[3'h7 - idx_r];
  always_comb begin
    en_nxt = en_r;
    ctl_nxt = ctl_r;
    pat_nxt = pat_r;
    ie_nxt = ie_r;
    idx_nxt = idx_r + 3'(txBitStrobe);
    if (wrStrobe && addr == 8'h17) en_nxt = wrData[1];
    if (wrStrobe && addr == 8'h12) ctl_nxt = wrData;
    if (wrStrobe && addr == 8'h13) pat_nxt = wrData;
    if (wrStrobe && addr == 8'h19) ie_nxt = wrData;
    if (!en_r || (txBitStrobe && idx_r == {1'b0, ctl_r[7:6]} + 3'h4)) begin
      idx_nxt = 3'h0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {en_r, ctl_r, pat_r, ie_r, idx_r} <= '0;
    end else begin
      {en_r, ctl_r, pat_r} <= {en_nxt, ctl_nxt, pat_nxt};
      {ie_r, idx_r} <= {ie_nxt, idx_nxt};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_idle; !$past(rdStrobe) |-> rdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_tx_hold; !txBitStrobe |=> $stable(txLineBit); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("line bit moved");
  property p_tx_off;
    txBitStrobe && !en_r && !txFrameSlot |=> txLineBit == $past(txPayloadBit);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("payload lost");
  property p_tx_frame;
    txBitStrobe && en_r && txFrameSlot && frameInsertEnable
      |=> txLineBit == $past(txFrameBit);
  endproperty
  a_tx_frame: assert property (p_tx_frame) else $error("frame bit");
  property p_tx_pat;
    txBitStrobe && en_r && !(txFrameSlot && frameInsertEnable)
      |=> txLineBit == $past(want);
  endproperty
  a_tx_pat: assert property (p_tx_pat) else $error("bad bit");
  property p_irq; $rose(irq) |-> ie_r != 8'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
  property p_rd_zero;
    rdStrobe && (addr == 8'h18 || addr > 8'h19) |=> rdData == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read not zero");
  property p_rd_ctl;
    rdStrobe && addr == 8'h12 |=> rdData == $past(ctl_r);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("readback");
  c_pat: cover property (txBitStrobe && en_r);
  c_irq: cover property ($rose(irq));
  c_stat: cover property (rdStrobe && addr == 8'h16 ##1 rdData != 8'h00);
endmodule
bind inband_loop_code_gen_detect loop_code_props #(.WINDOW_BITS(WINDOW_BITS))
  u_props (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
  .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
  .txBitStrobe(txBitStrobe), .txPayloadBit(txPayloadBit),
  .txFrameSlot(txFrameSlot), .txFrameBit(txFrameBit),
  .frameInsertEnable(frameInsertEnable), .txLineBit(txLineBit),
  .rxBitStrobe(rxBitStrobe), .rxBit(rxBit), .irq(irq));
`default_nettype wire

// File: testbench/t1_far_end.sv
// Far end model sending a repeating loop code or random line bits.
`timescale 1ns/1ps
`default_nettype none
module t1_far_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic on,
  input wire logic [7:0] pat,
  input wire logic [3:0] len,
  output logic rxBitStrobe,
  output logic rxBit
);
  int seed = 32'h2b3d;
  int idx;
  int cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rxBitStrobe <= 1'b0;
      rxBit <= 1'b0;
      idx = 0;
      cnt = 0;
    end else begin
      rxBitStrobe <= !rxBitStrobe;
      if (!rxBitStrobe) begin
        cnt = cnt + 1;
        idx = on ? (idx + 1) % int'(len) : 0;
        rxBit <= on ? pat[7 - idx] ^ (cnt % 100 == 0) :
          1'($random(seed));
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/inband_loop_code_gen_detect_test.sv
// Self-checking bench for the loop code block.
`timescale 1ns/1ps
`default_nettype none
module inband_loop_code_gen_detect_test;
  logic clk, rst, wrStrobe, rdStrobe, txBitStrobe, txPayloadBit, txFrameSlot;
  logic txFrameBit, frameInsertEnable, txLineBit, rxBitStrobe, rxBit, irq, on;
  logic [7:0] addr, wrData, rdData, d, v, m, p, pat;
  logic [3:0] len;
  int seed = 32'h5ff5;
  int failures = 0;
  int samples_checked = 0;
  inband_loop_code_gen_detect #(.WINDOW_BITS(50)) i_dut (.clk(clk), .rst(rst),
    .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .txBitStrobe(txBitStrobe), .txPayloadBit(txPayloadBit),
    .txFrameSlot(txFrameSlot), .txFrameBit(txFrameBit),
    .frameInsertEnable(frameInsertEnable), .txLineBit(txLineBit),
    .rxBitStrobe(rxBitStrobe), .rxBit(rxBit), .irq(irq));
  t1_far_end i_far (.clk(clk), .rst(rst), .on(on), .pat(pat), .len(len),
    .rxBitStrobe(rxBitStrobe), .rxBit(rxBit));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] val);
    @(posedge clk);
    addr <= a;
    wrData <= val;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask
  function automatic logic expTx(input logic [7:0] q, input int tl,
    input int i);
    return q[7 - (i % (tl + 5))];
  endfunction
  task automatic txRun(input logic en, input logic [7:0] q, input int tl);
    logic e;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      txBitStrobe <= 1'b1;
      txPayloadBit <= 1'($random(seed));
      txFrameSlot <= en && ($random(seed) % 7 == 0);
      frameInsertEnable <= 1'($random(seed));
      txFrameBit <= 1'($random(seed));
      @(posedge clk);
      txBitStrobe <= 1'b0;
      #1;
      e = (txFrameSlot && frameInsertEnable) ? txFrameBit :
        !en ? txPayloadBit : expTx(q, tl, i);
      chk({7'h0, txLineBit}, {7'h0, e});
    end
  endtask
  task automatic waitIrq;
    for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk({7'h0, irq}, 8'h01);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    {addr, wrData, wrStrobe, rdStrobe, txBitStrobe, txPayloadBit} = '0;
    {txFrameSlot, txFrameBit, frameInsertEnable, on, pat, len} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int a = 8'h11; a < 8'h1b; a++) begin
      rd(8'(a));
      chk(d, 8'h00);
      v = 8'($random(seed));
      wr(8'(a), v);
      rd(8'(a));
      m = (a == 8'h17) ? 8'h02 : (a == 8'h19) ? 8'hc0 : 8'hff;
      chk(d & m, (8'(a) inside {[8'h12:8'h15], 8'h17, 8'h19}) ? v & m : 8'h00);
    end
    wr(8'h19, 8'h00);
    for (int tl = 0; tl < 4; tl++) begin
      p = (tl == 0) ? 8'h87 : 8'($random(seed));
      wr(8'h12, {2'(tl), 6'h00});
      wr(8'h13, p);
      wr(8'h17, 8'h02);
      txRun(1'b1, p, tl);
      wr(8'h17, 8'h00);
    end
    txRun(1'b0, 8'h00, 0);
    wr(8'h12, 8'h22);
    wr(8'h14, 8'h87);
    wr(8'h15, 8'h9f);
    wr(8'h19, 8'hc0);
    {pat, len, on} <= {8'h80, 4'h5, 1'b1};
    waitIrq;
    rd(8'h16);
    chk(d, 8'h80);
    wr(8'h18, 8'h80);
    rd(8'h16);
    chk(d, 8'h00);
    chk({7'h0, irq}, 8'h00);
    len <= 4'h3;
    waitIrq;
    rd(8'h16);
    chk(d, 8'h40);
    wr(8'h19, 8'h80);
    chk({7'h0, irq}, 8'h00);
    wr(8'h19, 8'hc0);
    wr(8'h18, 8'h40);
    chk({7'h0, irq}, 8'h00);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h12);
    chk(d, 8'h00);
    final_report;
  end
endmodule
`default_nettype wire
